// ---- src/mag_pkg.sv ----
package mag_pkg;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [11:0] IDX_ALARM_PATTERN = 12'h330;
  localparam logic [11:0] IDX_TONE_CONTROL = 12'h331;
  localparam logic [11:0] IDX_TONE_DIVIDER_LOW = 12'h332;
  localparam logic [11:0] IDX_TONE_DIVIDER_HIGH = 12'h333;
  localparam logic [11:0] IDX_ALARM_IRQ_ENABLE = 12'h334;
  localparam logic [11:0] IDX_ALARM_IRQ_STATUS = 12'h335;
  localparam logic [11:0] IDX_ALARM_IRQ_CLEAR = 12'h336;

  // Values after reset.
  localparam logic [7:0] RST_ALARM_PATTERN = 8'h00;
  localparam logic [7:0] RST_TONE_CONTROL = 8'h00;
  localparam logic [7:0] RST_TONE_DIVIDER_LOW = 8'h00;
  localparam logic [7:0] RST_TONE_DIVIDER_HIGH = 8'h00;
  localparam logic [4:0] RST_ALARM_IRQ_ENABLE = 5'h00;

  // Field positions.
  localparam int TC_OUTPUT_SELECT = 0;
  localparam int TC_TONE_INVERT = 5;
  localparam int TC_COUNTER_CTRL_LO = 6;
  localparam int TC_COUNTER_CTRL_HI = 7;
  localparam int DH_TONE_COUNTER_RUN = 7;
  localparam int ALARM_IRQ_COUNT = 5;

  // Free-running counter prescale, in clock cycles per count.
  localparam int FRC_PRESCALE = 16;

  // Bus responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [1:0] {
    MAG_FRC_HOLD = 2'h0,
    MAG_FRC_RESTART = 2'h1,
    MAG_FRC_CLEAR = 2'h2,
    MAG_FRC_CLEAR_START = 2'h3
  } mag_frc_e;

  typedef struct packed {
    logic [1:0] counter_ctrl;
    logic tone_invert;
    logic [3:0] unused;
    logic output_select;
  } mag_tone_control_s;

endpackage

// ---- src/mag_tone_gen.sv ----
`timescale 1ns/1ps
// Overview of operation
// (R01) Two-bit counter field: hold, restart, clear, or clear then start the free-run counter.
// (R02) Tone invert bit set to 1 inverts the alarm waveform; 0 leaves it as is.
// (R03) Output select 0 drives the alarm waveform, 1 drives the melody waveform.
// (R04) Melody divider is 12 bits: low eight in one register, high four in the next.
// (R05) Tone counter run bit 0 stops and clears the melody counter; 1 runs it.
// (R06) Five alarm interrupt sources, each with its own enable; disabled ones raise nothing.
// (R07) An 8-bit alarm pattern, readable and writable, shapes the alarm tone.
// (R08) Software writes zero to unused control bits and the three unused enable bits.
module mag_tone_gen #(
  parameter int FRC_W = 8,
  parameter int PRESCALE = mag_pkg::FRC_PRESCALE
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [13:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [13:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic tone_out,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////////
  // Bus slave.

  // Bus slots and answer registers.
  logic [11:0] aw_idx_reg;
  logic aw_full_reg;
  logic [7:0] w_data_reg;
  logic w_lane_reg;
  logic w_full_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic do_write;
  // Register index of the read address now offered.
  logic [11:0] ar_idx;

  // Software registers and tone state.
  mag_pkg::mag_tone_control_s ctrl_reg;
  logic [7:0] pattern_reg;
  logic [7:0] div_lo_reg;
  logic run_reg;
  logic [3:0] div_hi_reg;
  // Enable and status hold one bit for each alarm source.
  logic [4:0] irq_en_reg;
  logic [4:0] irq_stat_reg;
  logic [FRC_W-1:0] frc_reg;
  logic frc_tick;
  logic [4:0] alarm_evt;

  // Ready is withheld while a write answer waits, so one write at most is under way.
  assign s_axi_awready = !aw_full_reg && !bvalid_reg;
  assign s_axi_wready = !w_full_reg && !bvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  // Only one read is under way; a new address waits until the answer is taken.
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  // The address and data slots fill in either order; the write lands when both are full.
  assign do_write = aw_full_reg && w_full_reg;
  assign ar_idx = s_axi_araddr[13:2];

  ////////////////////////////////////////////////////////////////////////////////
  // Write strobes, one for each register except the read-only status, high in the cycle the write lands.

  logic wr_lane;
  logic wr_pattern;
  logic wr_control;
  logic wr_div_lo;
  logic wr_div_hi;
  logic wr_irq_en;
  logic wr_irq_clr;
  logic addr_mapped;

  // A write with byte lane 0 off changes nothing but is still answered.
  assign wr_lane = do_write && w_lane_reg;
  assign wr_pattern = wr_lane && aw_idx_reg == mag_pkg::IDX_ALARM_PATTERN;
  assign wr_control = wr_lane && aw_idx_reg == mag_pkg::IDX_TONE_CONTROL;
  assign wr_div_lo = wr_lane && aw_idx_reg == mag_pkg::IDX_TONE_DIVIDER_LOW;
  assign wr_div_hi = wr_lane && aw_idx_reg == mag_pkg::IDX_TONE_DIVIDER_HIGH;
  assign wr_irq_en = wr_lane && aw_idx_reg == mag_pkg::IDX_ALARM_IRQ_ENABLE;
  assign wr_irq_clr = wr_lane && aw_idx_reg == mag_pkg::IDX_ALARM_IRQ_CLEAR;
  assign addr_mapped = aw_idx_reg >= mag_pkg::IDX_ALARM_PATTERN && aw_idx_reg <= mag_pkg::IDX_ALARM_IRQ_CLEAR;

  // The write address slot holds the index until the data has arrived too.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      aw_idx_reg <= 12'h000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_full_reg <= 1'b1;
      aw_idx_reg <= s_axi_awaddr[13:2];
    end else if (do_write) begin
      aw_full_reg <= 1'b0;
    end
  end

  // The write data slot keeps only the low byte and its lane strobe.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_reg <= 1'b0;
      w_data_reg <= 8'h00;
      w_lane_reg <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_full_reg <= 1'b1;
      w_data_reg <= s_axi_wdata[7:0];
      w_lane_reg <= s_axi_wstrb[0];
    end else if (do_write) begin
      w_full_reg <= 1'b0;
    end
  end

  // The write answer rises as the write lands and holds until the master takes it.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= mag_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= addr_mapped ? mag_pkg::RESP_OKAY : mag_pkg::RESP_DECERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // Read data is chosen from the offered index and latched when the address is taken.
  logic [31:0] rd_mux;
  logic rd_err;

  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_err = 1'b0;
    unique case (ar_idx)
      mag_pkg::IDX_ALARM_PATTERN: rd_mux = {24'h000000, pattern_reg}; // R07
      mag_pkg::IDX_TONE_CONTROL: rd_mux = {24'h000000, ctrl_reg};
      mag_pkg::IDX_TONE_DIVIDER_LOW: rd_mux = {24'h000000, div_lo_reg};
      mag_pkg::IDX_TONE_DIVIDER_HIGH: rd_mux = {24'h000000, run_reg, 3'h0, div_hi_reg};
      mag_pkg::IDX_ALARM_IRQ_ENABLE: rd_mux = {27'h0000000, irq_en_reg};
      mag_pkg::IDX_ALARM_IRQ_STATUS: rd_mux = {27'h0000000, irq_stat_reg};
      mag_pkg::IDX_ALARM_IRQ_CLEAR: rd_mux = 32'h0000_0000;
      default: rd_err = 1'b1;
    endcase
  end

  // The read answer holds until the master takes it.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= mag_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_mux;
      rresp_reg <= rd_err ? mag_pkg::RESP_DECERR : mag_pkg::RESP_OKAY;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Software registers.

  // Alarm pattern.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pattern_reg <= mag_pkg::RST_ALARM_PATTERN;
    end else if (wr_pattern) begin
      pattern_reg <= w_data_reg; // R07
    end
  end

  // Tone control; the unused bits are stored as written.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= mag_pkg::RST_TONE_CONTROL;
    end else if (wr_control) begin
      ctrl_reg <= w_data_reg; // R08
    end
  end

  // Low byte of the melody divider.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_lo_reg <= mag_pkg::RST_TONE_DIVIDER_LOW;
    end else if (wr_div_lo) begin
      div_lo_reg <= w_data_reg; // R04
    end
  end

  // High divider bits and the melody run bit share one register.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_reg <= mag_pkg::RST_TONE_DIVIDER_HIGH[mag_pkg::DH_TONE_COUNTER_RUN];
      div_hi_reg <= mag_pkg::RST_TONE_DIVIDER_HIGH[3:0];
    end else if (wr_div_hi) begin
      run_reg <= w_data_reg[mag_pkg::DH_TONE_COUNTER_RUN];
      div_hi_reg <= w_data_reg[3:0]; // R04
    end
  end

  // Interrupt enables.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_en_reg <= mag_pkg::RST_ALARM_IRQ_ENABLE;
    end else if (wr_irq_en) begin
      irq_en_reg <= w_data_reg[4:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Free-running counter with its prescaler.

  logic [15:0] pre_reg;
  logic frc_clear_pulse;
  logic frc_hold_clear;
  logic frc_counting;

  // The prescaler runs freely, so a restart resumes on the next tick and not at once.
  assign frc_tick = (pre_reg == 16'(PRESCALE - 1));
  // Any control write with the high counter bit set clears the count once.
  assign frc_clear_pulse = wr_control && w_data_reg[mag_pkg::TC_COUNTER_CTRL_HI];
  assign frc_hold_clear = ctrl_reg.counter_ctrl == mag_pkg::MAG_FRC_CLEAR;
  assign frc_counting = ctrl_reg.counter_ctrl[0];

  // Prescaler that paces the free-running counter.
  always_ff @(posedge aclk) begin
    if (!aresetn || frc_tick) begin
      pre_reg <= 16'h0000;
    end else begin
      pre_reg <= pre_reg + 16'h0001;
    end
  end

  // A clear takes priority over counting in the same cycle.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frc_reg <= '0;
    end else if (frc_clear_pulse || frc_hold_clear) begin
      frc_reg <= '0; // R01
    end else if (frc_tick && frc_counting) begin
      frc_reg <= frc_reg + 1'b1; // R01
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Alarm interrupts.

  // Source i fires on a tick while counting when the low i+4 count bits are all ones.
  genvar gi;
  generate
    for (gi = 0; gi < mag_pkg::ALARM_IRQ_COUNT; gi++) begin : g_evt
      assign alarm_evt[gi] = frc_tick && frc_counting && (&frc_reg[gi+3:0]);
    end
  endgenerate

  // An alarm in the same cycle as its clear wins, so no alarm is lost.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_reg <= 5'h00;
    end else begin
      for (int i = 0; i < mag_pkg::ALARM_IRQ_COUNT; i++) begin
        if (alarm_evt[i] && irq_en_reg[i]) begin
          irq_stat_reg[i] <= 1'b1; // R06
        end else if (wr_irq_clr && w_data_reg[i]) begin
          irq_stat_reg[i] <= 1'b0;
        end
      end
    end
  end

  // The interrupt line follows the enabled status one cycle later.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_reg & irq_en_reg); // R06
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Melody divider and tone output.

  logic [11:0] mel_cnt_reg;
  logic mel_wave_reg;
  logic [11:0] divider;
  logic alarm_wave;
  logic mel_wrap;

  // The divider halves are written apart, so the pitch may pass through a mixed value.
  assign divider = {div_hi_reg, div_lo_reg}; // R04
  // The pattern bit picked by the top count bits gates a square wave at half the tick rate.
  assign alarm_wave = pattern_reg[frc_reg[FRC_W-1:FRC_W-3]] & frc_reg[0]; // R07
  assign mel_wrap = mel_cnt_reg >= divider;

  // Each half period of the melody lasts the divider plus one clocks.
  always_ff @(posedge aclk) begin
    if (!aresetn || !run_reg) begin
      mel_cnt_reg <= 12'h000; // R05
      mel_wave_reg <= 1'b0;
    end else if (mel_wrap) begin
      mel_cnt_reg <= 12'h000; // R05
      mel_wave_reg <= !mel_wave_reg;
    end else begin
      mel_cnt_reg <= mel_cnt_reg + 12'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Tone output select.

  logic alarm_tone;
  logic tone_next;

  assign alarm_tone = alarm_wave ^ ctrl_reg.tone_invert; // R02
  assign tone_next = ctrl_reg.output_select ? mel_wave_reg : alarm_tone; // R03

  // The output is registered so the sounder sees no glitch when the select changes.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tone_out <= 1'b0;
    end else begin
      tone_out <= tone_next;
    end
  end

endmodule // mag_tone_gen

// ---- sim/mag_tone_gen_chk.sv ----
`timescale 1ns/1ps
module mag_tone_gen_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic tone_out,
  input wire logic irq
);
  default clocking dc @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_AR_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_R_STAND: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  AST_AR_REFUSE: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  AST_B_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
    else $error("write answer late");
  AST_B_REFUSE: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
  AST_B_DROP: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer repeated");
  AST_IRQ_FALL: assert property ($fell(irq) |-> $past(s_axi_bvalid))
    else $error("interrupt dropped without a write");
  AST_RST_QUIET: assert property ($rose(aresetn) |-> !irq && !tone_out && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs active after reset");
  cover property ($rose(irq));
  cover property ($rose(tone_out));
  cover property (s_axi_bvalid && s_axi_bresp == 2'h3);
endmodule // mag_tone_gen_chk
bind mag_tone_gen mag_tone_gen_chk chk_u (.*);

// ---- sim/mag_buzzer_model.sv ----
`timescale 1ns/1ps
module mag_buzzer_model (
  input wire logic aclk,
  input wire logic clr,
  input wire logic tone_out,
  output int edges
);
  logic last = 1'b0;
  // Counts rising edges of the sounder drive.
  always @(posedge aclk) begin
    edges <= clr ? 0 : edges + int'(tone_out && !last);
    last <= tone_out;
  end
endmodule // mag_buzzer_model

// ---- sim/mag_tone_gen_tb.sv ----
`timescale 1ns/1ps
module mag_tone_gen_tb;
  localparam logic [11:0] PAT = mag_pkg::IDX_ALARM_PATTERN;
  localparam logic [11:0] CTL = mag_pkg::IDX_TONE_CONTROL;
  localparam logic [11:0] DLO = mag_pkg::IDX_TONE_DIVIDER_LOW;
  localparam logic [11:0] DHI = mag_pkg::IDX_TONE_DIVIDER_HIGH;
  localparam logic [11:0] IEN = mag_pkg::IDX_ALARM_IRQ_ENABLE;
  localparam logic [11:0] IST = mag_pkg::IDX_ALARM_IRQ_STATUS;
  logic aclk = 1'b0, aresetn = 1'b0, clr = 1'b0;
  logic [13:0] s_axi_awaddr = 14'h0, s_axi_araddr = 14'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, tone_out, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [33:0] rq[$], bq[$];
  logic [7:0] pat;
  int error_cnt = 0, cmp_count = 0, edges;
  mag_tone_gen #(.PRESCALE(2)) dut_u (.*);
  mag_buzzer_model buz_u (.aclk(aclk), .clr(clr), .tone_out(tone_out), .edges(edges));
  initial forever #2.5 aclk = ~aclk;
  task automatic chk(input string n, input logic [33:0] s, input logic [33:0] e);
    cmp_count++;
    if (s !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [11:0] i, input logic [7:0] d, input logic [1:0] r = 2'h0);
    @(posedge aclk);
    bq.push_back({32'h0, r});
    s_axi_awaddr <= {i, 2'h0};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!(s_axi_bvalid && s_axi_bready));
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] i, input logic [31:0] d, input logic [1:0] r = 2'h0);
    @(posedge aclk);
    rq.push_back({r, d});
    s_axi_araddr <= {i, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!(s_axi_rvalid && s_axi_rready));
    s_axi_rready <= 1'b0;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic count(input int n);
    clr <= 1'b1;
    @(posedge aclk);
    clr <= 1'b0;
    idle(n);
  endtask
  task automatic rst(input int n);
    aresetn <= 1'b0;
    idle(n);
    aresetn <= 1'b1;
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready) chk("read", {s_axi_rresp, s_axi_rdata}, rq.pop_front());
    if (s_axi_bvalid && s_axi_bready) chk("bresp", {32'h0, s_axi_bresp}, bq.pop_front());
  end
  initial begin
    #60us;
    error_cnt++;
    finish_test();
  end
  initial begin
    void'($urandom(89));
    rst(5);
    for (int k = 0; k < 7; k++) rd(PAT + 12'(k), 32'h0);
    pat = 8'($urandom);
    wr(PAT, pat);
    rd(PAT, {24'h0, pat});
    wr(DLO, ~pat);
    rd(DLO, {24'h0, ~pat});
    wr(DHI, 8'h0A);
    rd(DHI, 32'h0A);
    rd(12'h337, 32'h0, mag_pkg::RESP_DECERR);
    wr(12'h337, 8'h5A, mag_pkg::RESP_DECERR);
    $display("test registers done");
    wr(DLO, 8'h03);
    wr(DHI, 8'h80);
    wr(CTL, 8'h01);
    count(160);
    chk("melody edges", 34'(edges inside {[18:22]}), 34'h1);
    wr(DHI, 8'h03);
    count(40);
    chk("stopped edges", 34'(edges), 34'h0);
    chk("stopped tone", 34'(tone_out), 34'h0);
    $display("test melody done");
    rst(3);
    wr(IEN, 8'h01);
    wr(CTL, 8'hC0);
    idle(600);
    wr(CTL, 8'h00);
    rd(IST, 32'h01);
    chk("irq set", 34'(irq), 34'h1);
    wr(mag_pkg::IDX_ALARM_IRQ_CLEAR, 8'h1F);
    rd(IST, 32'h00);
    chk("irq clear", 34'(irq), 34'h0);
    wr(IEN, 8'h1F);
    wr(CTL, 8'hC0);
    idle(600);
    wr(CTL, 8'h00);
    rd(IST, 32'h1F);
    $display("test interrupts done");
    wr(PAT, 8'hFF);
    wr(CTL, 8'h80);
    count(100);
    chk("cleared edges", 34'(edges), 34'h0);
    wr(CTL, 8'h40);
    count(100);
    chk("restart edges", 34'(edges > 10), 34'h1);
    wr(CTL, 8'h00);
    count(100);
    chk("hold edges", 34'(edges), 34'h0);
    wr(PAT, 8'h00);
    wr(CTL, 8'h20);
    idle(3);
    chk("inverted tone", 34'(tone_out), 34'h1);
    wr(CTL, 8'h00);
    idle(3);
    chk("plain tone", 34'(tone_out), 34'h0);
    $display("test alarm done");
    finish_test();
  end
endmodule // mag_tone_gen_tb
